//--- core/cio_framer.sv
`timescale 1ns/1ps

module cio_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  // refuse depths the wrapping pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  wire          full  = (wp_q ^ rp_q) == {1'b1, {AW{1'b0}}};
  wire          empty = wp_q == rp_q;
  wire          push  = i_in_valid && !full;
  wire          pop   = i_out_ready && !empty;

  // handshake on both sides
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rp_q[AW-1:0]];

  // storage
  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem[wp_q[AW-1:0]] <= i_in_data;
  end

  // pointers
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule

module cio_framer
  import cio_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS,
  parameter int PERIOD_MS = RPT_MS,
  parameter int FIFO_D    = 32
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire logic [6:0]  i_node_id,
  input  wire logic        i_state_cmd_valid,
  input  wire logic [7:0]  i_state_cmd,
  input  wire logic        i_ain_valid,
  input  wire logic [63:0] i_ain,
  input  wire logic        i_supply_valid,
  input  wire logic [15:0] i_supply_voltage_input,
  input  wire logic        i_cfg_wr,
  input  wire logic [15:0] i_cfg_ain_delta,
  input  wire logic [15:0] i_cfg_pwr_delta,
  input  wire logic        i_din_evt_en,
  input  wire logic        i_ain_evt_en,
  input  wire logic        i_tx_lost,
  input  wire logic        i_rx_lost,
  input  wire logic        i_short_frame,
  input  wire logic        i_busoff_recovered,
  input  wire logic [15:0] i_dac_status,
  input  wire logic        i_link_fail,
  input  wire logic        i_setup_fail,
  output logic             o_frame_valid,
  input  wire logic        i_frame_ready,
  output logic [10:0]      o_frame_id,
  output logic [3:0]       o_frame_dlc,
  output logic [63:0]      o_frame_data,
  output logic [7:0]       o_node_state,
  output logic [7:0]       o_err_status
);
  // refuse timing values the report counters cannot hold
  if (MS_CYCLES < 1 || PERIOD_MS < 1 || PERIOD_MS >= (1 << MS_W))
  begin : g_bad_timing
    $error("bad timing parameters");
  end

  cio_node_t      node_q;
  logic           boot_q;
  logic [15:0]    ain_dlt_q;
  logic [15:0]    pwr_dlt_q;
  logic [63:0]    ain_s_q;
  logic [63:0]    ain_r_q;
  logic [15:0]    pwr_s_q;
  logic [15:0]    pwr_r_q;
  logic [31:0]    div_q;
  logic [MS_W-1:0] ain_ms_q;
  logic [MS_W-1:0] pwr_ms_q;
  logic [MS_W-1:0] hb_ms_q;
  logic [EV_N-1:0] ep_q;
  logic [EV_N-1:0] ep_d;
  logic [EV_N-1:0] ev_set;
  logic [EV_N-1:0] ev_clr;
  logic [15:0]    dac_last_q;
  logic [15:0]    dac_snap_q;
  logic           warn_q;
  logic           link_q;
  logic           setup_q;
  logic           can_q;
  logic [7:0]     gs_q;
  logic           fifo_rdy;
  logic           fifo_ov;
  logic [FRAME_W-1:0] fifo_od;
  logic [3:0]     e_idx;
  logic [15:0]    e_code;
  logic [39:0]    e_det;

  // node state code and which traffic it allows
  wire [7:0] ns_code = node_q == NODE_OPER  ? NS_OPER :
                       node_q == NODE_STOP  ? NS_STOP :
                       node_q == NODE_PREOP ? NS_PREOP : NS_BOOT;
  wire pd_ok   = node_q == NODE_OPER;
  wire emcy_ok = node_q != NODE_STOP;
  wire [10:0] node11 = {4'h0, i_node_id};

  // change detection against last reported values
  logic [3:0] ch_chg;
  genvar gi;
  for (gi = 0; gi < 4; gi++)
  begin : g_ch
    wire [15:0] s = ain_s_q[gi*16 +: 16];
    wire [15:0] r = ain_r_q[gi*16 +: 16];
    wire [15:0] d = s > r ? s - r : r - s;
    assign ch_chg[gi] = d >= ain_dlt_q;
  end
  wire [15:0] pwr_d   = pwr_s_q > pwr_r_q ? pwr_s_q - pwr_r_q
                                          : pwr_r_q - pwr_s_q;
  wire        ain_chg = |ch_chg;
  wire        pwr_chg = pwr_d >= pwr_dlt_q;
  wire [MS_W-1:0] per = MS_W'(PERIOD_MS);
  wire        ms_tick = div_q == 32'(MS_CYCLES - 1);

  // requests and fixed priority grant
  wire req_emcy = emcy_ok && (|ep_q);
  wire req_hb   = node_q != NODE_BOOT && hb_ms_q >= per;
  wire req_ain  = pd_ok && (ain_chg || ain_ms_q >= per);
  wire req_pwr  = pd_ok && (pwr_chg || pwr_ms_q >= per);
  wire g_boot   = fifo_rdy && boot_q;
  wire g_emcy   = fifo_rdy && !boot_q && req_emcy;
  wire g_hb     = fifo_rdy && !boot_q && !req_emcy && req_hb;
  wire g_ain    = fifo_rdy && !boot_q && !req_emcy && !req_hb && req_ain;
  wire g_pwr    = fifo_rdy && !boot_q && !req_emcy && !req_hb &&
                  !req_ain && req_pwr;
  wire push     = g_boot || g_emcy || g_hb || g_ain || g_pwr;

  // pick the pending emergency with the lowest index
  always_comb
  begin
    e_idx = 4'h0;
    for (int k = EV_N - 1; k >= 0; k--)
      if (ep_q[k])
        e_idx = 4'(k);
  end

  // emergency code and detail bytes per source
  wire dac_ovc   = |(dac_snap_q & DS_OVC_MASK);
  wire dac_therm = |(dac_snap_q & DS_THERM_MASK);
  always_comb
  begin
    e_det = '0;
    case (e_idx)
      4'(EV_WARN): e_code = EC_WARN;
      4'(EV_TX):   e_code = EC_TXLOST;
      4'(EV_RX):   e_code = EC_RXLOST;
      4'(EV_SHRT): e_code = EC_SHORT;
      4'(EV_BOFF): e_code = EC_BUSOFF;
      4'(EV_DAC):
      begin
        e_code = dac_ovc ? EC_OVERCUR :
                 dac_therm ? EC_THERMAL : EC_CLEAR;
        e_det  = {dac_snap_q, TAG_DAC};
      end
      4'(EV_LSET):
      begin
        e_code = EC_LINK;
        e_det  = TAG_LINK;
      end
      4'(EV_LCLR):
      begin
        e_code = EC_CLEAR;
        e_det  = TAG_LINK;
      end
      4'(EV_SSET):
      begin
        e_code = EC_LINK;
        e_det  = TAG_SETUP;
      end
      4'(EV_SCLR):
      begin
        e_code = EC_CLEAR;
        e_det  = TAG_SETUP;
      end
      default: e_code = EC_CLEAR;
    endcase
  end

  // frame assembly, byte 0 in the low bits
  wire [10:0] push_id  = g_boot || g_hb ? ID_HB + node11 :
                         g_emcy ? ID_EMCY + node11 :
                         g_ain  ? ID_AIN + node11 :
                                  ID_PWR + node11;
  wire [3:0]  push_dlc = g_boot || g_hb ? DLC_HB :
                         g_emcy ? DLC_EMCY :
                         g_ain  ? DLC_AIN : DLC_PWR;
  wire [63:0] push_dat = g_boot ? {56'h0, NS_BOOT} :
                         g_hb   ? {56'h0, ns_code} :
                         g_emcy ? {e_det, gs_q, e_code} :
                         g_ain  ? ain_s_q :
                                  {48'h0, pwr_s_q};

  // error events, gated off while stopped
  wire warn_lvl = !i_din_evt_en || !i_ain_evt_en;
  always_comb
  begin
    ev_set          = '0;
    ev_set[EV_WARN] = warn_lvl && !warn_q;
    ev_set[EV_TX]   = i_tx_lost;
    ev_set[EV_RX]   = i_rx_lost;
    ev_set[EV_SHRT] = i_short_frame;
    ev_set[EV_BOFF] = i_busoff_recovered;
    ev_set[EV_DAC]  = i_dac_status != dac_last_q;
    ev_set[EV_LSET] = i_link_fail && !link_q;
    ev_set[EV_LCLR] = !i_link_fail && link_q;
    ev_set[EV_SSET] = i_setup_fail && !setup_q;
    ev_set[EV_SCLR] = !i_setup_fail && setup_q;
    ev_set          = emcy_ok ? ev_set : '0;
    ev_clr          = '0;
    ev_clr[e_idx]   = g_emcy;
    ep_d            = (ep_q & ~ev_clr) | ev_set;        // set wins
  end

  // category bits; summary follows the active categories
  wire cat_ovc   = |(i_dac_status & DS_OVC_MASK);
  wire cat_therm = |(i_dac_status & DS_THERM_MASK);
  wire cat_link  = i_link_fail || i_setup_fail;
  wire can_d     = can_q || i_tx_lost || i_rx_lost ||
                   i_short_frame || i_busoff_recovered;
  wire [7:0] gs_d = {2'b00, cat_link, can_d, cat_therm, 1'b0, cat_ovc,
                     cat_link || can_d || cat_therm || cat_ovc};

  // node state machine
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      node_q <= NODE_BOOT;
      boot_q <= 1'b1;
    end
    else if (g_boot)
    begin
      node_q <= NODE_PREOP;
      boot_q <= 1'b0;
    end
    else if (i_state_cmd_valid && node_q != NODE_BOOT)
    begin
      case (i_state_cmd)
        NS_OPER:  node_q <= NODE_OPER;
        NS_STOP:  node_q <= NODE_STOP;
        NS_PREOP: node_q <= NODE_PREOP;
        default:  node_q <= node_q;
      endcase
    end
  end

  // thresholds, factory values at reset
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ain_dlt_q <= AIN_DELTA_RST;
      pwr_dlt_q <= PWR_DELTA_RST;
    end
    else if (i_cfg_wr && node_q != NODE_STOP)
    begin
      ain_dlt_q <= i_cfg_ain_delta;
      pwr_dlt_q <= i_cfg_pwr_delta;
    end
  end

  // raw samples on every poll, last reported copies
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ain_s_q <= '0;
      ain_r_q <= '0;
      pwr_s_q <= '0;
      pwr_r_q <= '0;
    end
    else
    begin
      if (i_ain_valid)
        ain_s_q <= i_ain;
      if (i_supply_valid)
        pwr_s_q <= i_supply_voltage_input;
      if (g_ain)
        ain_r_q <= ain_s_q;
      if (g_pwr)
        pwr_r_q <= pwr_s_q;
    end
  end

  // millisecond divider and report timers
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      div_q    <= '0;
      ain_ms_q <= '0;
      pwr_ms_q <= '0;
      hb_ms_q  <= '0;
    end
    else
    begin
      div_q <= ms_tick ? '0 : div_q + 32'h0000_0001;
      if (g_ain)
        ain_ms_q <= '0;
      else if (ms_tick && ain_ms_q < per)
        ain_ms_q <= ain_ms_q + 1'b1;
      if (g_pwr)
        pwr_ms_q <= '0;
      else if (ms_tick && pwr_ms_q < per)
        pwr_ms_q <= pwr_ms_q + 1'b1;
      if (g_hb || g_boot)
        hb_ms_q <= '0;
      else if (ms_tick && hb_ms_q < per)
        hb_ms_q <= hb_ms_q + 1'b1;
    end
  end

  // error tracking
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ep_q       <= '0;
      dac_last_q <= '0;
      dac_snap_q <= '0;
      warn_q     <= 1'b0;
      link_q     <= 1'b0;
      setup_q    <= 1'b0;
      can_q      <= 1'b0;
      gs_q       <= '0;
    end
    else
    begin
      ep_q       <= ep_d;
      dac_last_q <= i_dac_status;
      if (ev_set[EV_DAC])
        dac_snap_q <= i_dac_status;
      warn_q     <= warn_lvl;
      link_q     <= i_link_fail;
      setup_q    <= i_setup_fail;
      can_q      <= can_d;
      gs_q       <= gs_d;
    end
  end

  // outgoing frame queue
  cio_fifo #(
    .W     (FRAME_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (push),
    .o_in_ready  (fifo_rdy),
    .i_in_data   ({push_id, push_dlc, push_dat}),
    .o_out_valid (fifo_ov),
    .i_out_ready (!o_frame_valid || i_frame_ready),
    .o_out_data  (fifo_od)
  );

  // registered output stage
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_frame_valid <= 1'b0;
      o_frame_id    <= '0;
      o_frame_dlc   <= '0;
      o_frame_data  <= '0;
      o_node_state  <= NS_BOOT;
      o_err_status  <= '0;
    end
    else
    begin
      if (!o_frame_valid || i_frame_ready)
      begin
        o_frame_valid <= fifo_ov;
        o_frame_id    <= fifo_od[78:68];
        o_frame_dlc   <= fifo_od[67:64];
        o_frame_data  <= fifo_od[63:0];
      end
      o_node_state <= ns_code;
      o_err_status <= gs_q;
    end
  end

  property p_boot;
    @(posedge i_core_clk) disable iff (!i_nrst)
    g_boot |=> node_q == NODE_PREOP && !boot_q && hb_ms_q == '0;
  endproperty
  a_boot: assert property (p_boot) else $error("bootup not left");

  property p_ain_frame;
    @(posedge i_core_clk) disable iff (!i_nrst)
    g_ain |-> push_id == ID_AIN + node11 && push_dlc == DLC_AIN &&
      push_dat == ain_s_q;
  endproperty
  a_ain_frame: assert property (p_ain_frame) else $error("ain frame");

  // grant, then reported copy and timer follow
  sequence s_ain_sent;
    g_ain ##1 ain_r_q == $past(ain_s_q) && ain_ms_q == '0;
  endsequence

  property p_ain_chg;
    @(posedge i_core_clk) disable iff (!i_nrst)
    pd_ok && ain_chg && fifo_rdy && !boot_q && !req_emcy && !req_hb
      |-> s_ain_sent;
  endproperty
  a_ain_chg: assert property (p_ain_chg) else $error("ain not sent");

  property p_pwr_frame;
    @(posedge i_core_clk) disable iff (!i_nrst)
    g_pwr |-> push_id == ID_PWR + node11 && push_dlc == DLC_PWR;
  endproperty
  a_pwr_frame: assert property (p_pwr_frame) else $error("pwr frame");

  property p_stop;
    @(posedge i_core_clk) disable iff (!i_nrst)
    node_q == NODE_STOP |-> !g_ain && !g_pwr && !g_emcy;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped sent data");

  property p_preop;
    @(posedge i_core_clk) disable iff (!i_nrst)
    node_q == NODE_PREOP |-> !g_ain && !g_pwr;
  endproperty
  a_preop: assert property (p_preop) else $error("preop sent data");

  // heartbeat frame content, then timer restart
  sequence s_hb_sent;
    push_id == ID_HB + node11 && push_dat[7:0] == ns_code
      ##1 hb_ms_q == '0;
  endsequence

  property p_hb;
    @(posedge i_core_clk) disable iff (!i_nrst)
    g_hb |-> s_hb_sent;
  endproperty
  a_hb: assert property (p_hb) else $error("heartbeat");

  property p_can_sticky;
    @(posedge i_core_clk) disable iff (!i_nrst)
    gs_q[GS_CAN] |=> gs_q[GS_CAN] && gs_q[GS_ANY];
  endproperty
  a_can_sticky: assert property (p_can_sticky) else $error("can bit");

  property p_warn;
    @(posedge i_core_clk) disable iff (!i_nrst)
    g_emcy && e_idx == 4'(EV_WARN) |-> push_dat[15:0] == EC_WARN &&
      push_dat[23:16] == gs_q;
  endproperty
  a_warn: assert property (p_warn) else $error("warning code");
endmodule

//--- core/cio_pkg.sv
package cio_pkg;
  // clock and report timing
  localparam int CLK_HZ     = 40_000_000;
  localparam int TICK_MS    = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int RPT_MS     = 500;
  localparam int MS_W       = 10;
  // frame identifiers, before node number is added
  localparam logic [10:0] ID_EMCY = 11'h080;
  localparam logic [10:0] ID_AIN  = 11'h280;
  localparam logic [10:0] ID_PWR  = 11'h380;
  localparam logic [10:0] ID_HB   = 11'h700;
  // data lengths
  localparam logic [3:0] DLC_AIN  = 4'h8;
  localparam logic [3:0] DLC_PWR  = 4'h2;
  localparam logic [3:0] DLC_HB   = 4'h1;
  localparam logic [3:0] DLC_EMCY = 4'h8;
  // node state codes carried in the heartbeat
  localparam logic [7:0] NS_BOOT  = 8'h00;
  localparam logic [7:0] NS_STOP  = 8'h04;
  localparam logic [7:0] NS_OPER  = 8'h05;
  localparam logic [7:0] NS_PREOP = 8'h7f;
  // factory change thresholds
  localparam logic [15:0] AIN_DELTA_RST = 16'h000a;
  localparam logic [15:0] PWR_DELTA_RST = 16'h0032;
  // emergency codes
  localparam logic [15:0] EC_CLEAR   = 16'h0000;
  localparam logic [15:0] EC_WARN    = 16'h8000;
  localparam logic [15:0] EC_TXLOST  = 16'h8100;
  localparam logic [15:0] EC_RXLOST  = 16'h8110;
  localparam logic [15:0] EC_SHORT   = 16'h8210;
  localparam logic [15:0] EC_BUSOFF  = 16'h8140;
  localparam logic [15:0] EC_OVERCUR = 16'h2310;
  localparam logic [15:0] EC_THERMAL = 16'h4200;
  localparam logic [15:0] EC_LINK    = 16'h5000;
  // detail tags, byte 3 in the low bits
  localparam logic [23:0] TAG_DAC   = 24'h43_4144;
  localparam logic [39:0] TAG_LINK  = 40'h41_4449_5053;
  localparam logic [39:0] TAG_SETUP = 40'h43_4144_5748;
  // general status bit positions and converter status masks
  localparam int GS_ANY   = 0;
  localparam int GS_OVC   = 1;
  localparam int GS_THERM = 3;
  localparam int GS_CAN   = 4;
  localparam int GS_LINK  = 5;
  localparam logic [15:0] DS_OVC_MASK   = 16'h1818;
  localparam logic [15:0] DS_THERM_MASK = 16'h2020;
  // emergency sources, lowest index sent first
  localparam int EV_WARN = 0;
  localparam int EV_TX   = 1;
  localparam int EV_RX   = 2;
  localparam int EV_SHRT = 3;
  localparam int EV_BOFF = 4;
  localparam int EV_DAC  = 5;
  localparam int EV_LSET = 6;
  localparam int EV_LCLR = 7;
  localparam int EV_SSET = 8;
  localparam int EV_SCLR = 9;
  localparam int EV_N    = 10;
  localparam int FRAME_W = 79;
  typedef enum logic [1:0] {NODE_BOOT, NODE_PREOP, NODE_OPER, NODE_STOP}
    cio_node_t;
endpackage

//--- test/cio_sink.sv
`timescale 1ns/1ps

module cio_sink (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_slow,
  output logic      o_frame_ready
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // slow mode takes one frame in three cycles
  assign cnt_d = (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
  assign o_frame_ready = !i_slow || (cnt_q == 2'h0);

  // stall phase counter
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_d;
  end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps

module testbench import cio_pkg::*;;
  localparam logic [10:0] NODE = 11'h005;
  logic        clk, nrst, slow, rdy, cmd_v, ain_v, sup_v;
  logic [7:0]  cmd;
  logic [63:0] ain, d;
  logic [15:0] sup, dac;
  logic        din_en, ain_en, txl, rxl, shf, bor, lnk, stp, hit;
  logic        fv;
  logic [10:0] fid;
  logic [3:0]  fdlc;
  logic [63:0] fdat;
  logic [7:0]  nst, est;
  logic [3:0]  dlc;
  int          err_total, tests_run;

  cio_framer #(.MS_CYCLES(4), .PERIOD_MS(10), .FIFO_D(32)) dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_node_id(NODE[6:0]),
    .i_state_cmd_valid(cmd_v), .i_state_cmd(cmd),
    .i_ain_valid(ain_v), .i_ain(ain), .i_supply_valid(sup_v),
    .i_supply_voltage_input(sup), .i_cfg_wr(1'b0),
    .i_cfg_ain_delta(16'h0000), .i_cfg_pwr_delta(16'h0000),
    .i_din_evt_en(din_en), .i_ain_evt_en(ain_en), .i_tx_lost(txl),
    .i_rx_lost(rxl), .i_short_frame(shf), .i_busoff_recovered(bor),
    .i_dac_status(dac), .i_link_fail(lnk), .i_setup_fail(stp),
    .o_frame_valid(fv), .i_frame_ready(rdy), .o_frame_id(fid),
    .o_frame_dlc(fdlc), .o_frame_data(fdat), .o_node_state(nst),
    .o_err_status(est));

  cio_sink u_sink (.i_core_clk(clk), .i_nrst(nrst), .i_slow(slow),
    .o_frame_ready(rdy));

  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // frame accepted by the sink at the following rising edge
  task automatic get_frame(input logic [10:0] id, input int lim);
    int n;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++)
    begin
      @(negedge clk);
      if (fv === 1'b1 && rdy === 1'b1 && fid === id + NODE)
      begin
        hit = 1'b1;
        d = fdat;
        dlc = fdlc;
      end
    end
  endtask

  task automatic state_cmd(input logic [7:0] c);
    @(negedge clk);
    cmd_v = 1'b1;
    cmd = c;
    @(negedge clk);
    cmd_v = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_boot();
    get_frame(ID_HB, 20);
    check(hit, 1'b1);
    check({dlc, d}, {DLC_HB, 56'h0, NS_BOOT});
    check(nst, NS_PREOP);
    state_cmd(NS_OPER);
    check(nst, NS_OPER);
  endtask

  task automatic sample_ain(input logic [63:0] v);
    @(negedge clk);
    ain = v;
    ain_v = 1'b1;
    @(negedge clk);
    ain_v = 1'b0;
  endtask

  task automatic t_ain();
    sample_ain(64'h0400_0300_0200_0100);
    get_frame(ID_AIN, 20);
    check({hit, dlc, d}, {1'b1, DLC_AIN, ain});
    sample_ain(64'h0400_0300_0209_0100);
    get_frame(ID_AIN, 10);
    check(hit, 1'b0);
    sample_ain(64'h0400_0300_020a_0100);
    get_frame(ID_AIN, 10);
    check({hit, d}, {1'b1, ain});
  endtask

  task automatic t_supply();
    slow = 1'b1;
    @(negedge clk);
    sup = 16'h0123;
    sup_v = 1'b1;
    @(negedge clk);
    sup_v = 1'b0;
    get_frame(ID_PWR, 20);
    check({hit, dlc, d}, {1'b1, DLC_PWR, 48'h0, sup});
    get_frame(ID_HB, 60);
    check({hit, d[7:0]}, {1'b1, NS_OPER});
    get_frame(ID_PWR, 60);
    check({hit, d[15:0]}, {1'b1, sup});
    slow = 1'b0;
  endtask

  // one pulse per CAN error source, each reported on its own frame, then warning and link levels
  task automatic t_emcy();
    logic [15:0] codes [4];
    int i;
    codes = '{EC_TXLOST, EC_RXLOST, EC_SHORT, EC_BUSOFF};
    for (i = 0; i < 4; i++)
    begin
      @(negedge clk);
      {bor, shf, rxl, txl} = 4'h1 << i;
      @(negedge clk);
      {bor, shf, rxl, txl} = 4'h0;
      get_frame(ID_EMCY, 20);
      check({hit, dlc, d[15:0]}, {1'b1, DLC_EMCY, codes[i]});
    end
    check(est, 8'h11);
    ain_en = 1'b0;
    get_frame(ID_EMCY, 20);
    check({hit, d[15:0], est}, {1'b1, EC_WARN, 8'h11});
    ain_en = 1'b1;
    lnk = 1'b1;
    get_frame(ID_EMCY, 20);
    check({hit, d[15:0], d[63:24]}, {1'b1, EC_LINK, TAG_LINK});
    repeat (3) @(negedge clk);
    check(est, 8'h31);
    lnk = 1'b0;
    get_frame(ID_EMCY, 20);
    check({hit, d[15:0], d[63:24]}, {1'b1, EC_CLEAR, TAG_LINK});
    repeat (3) @(negedge clk);
    check(est, 8'h11);
  endtask

  // converter status: overcurrent, thermal, then all clear
  task automatic t_dac();
    logic [15:0] st [3];
    logic [15:0] ec [3];
    logic [7:0]  gs [3];
    int i;
    st = '{16'h0008, 16'h0020, 16'h0000};
    ec = '{EC_OVERCUR, EC_THERMAL, EC_CLEAR};
    gs = '{8'h13, 8'h19, 8'h11};
    for (i = 0; i < 3; i++)
    begin
      dac = st[i];
      get_frame(ID_EMCY, 20);
      check({hit, d}, {1'b1, st[i], TAG_DAC, gs[i], ec[i]});
      repeat (3) @(negedge clk);
      check(est, gs[i]);
    end
  endtask

  task automatic t_stop();
    state_cmd(NS_STOP);
    txl = 1'b1;
    @(negedge clk);
    txl = 1'b0;
    get_frame(ID_EMCY, 30);
    check(hit, 1'b0);
    get_frame(ID_HB, 60);
    check({hit, d[7:0]}, {1'b1, NS_STOP});
  endtask

  task automatic results();
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // 25 ns clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end

  initial
  begin
    err_total = 0;
    tests_run = 0;
    {nrst, slow, cmd_v, ain_v, sup_v, txl, rxl, shf, bor, lnk, stp} = '0;
    {din_en, ain_en} = 2'b11;
    {cmd, ain, sup, dac, d, dlc, hit} = '0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_boot();
    t_ain();
    t_supply();
    t_emcy();
    t_dac();
    t_stop();
    results();
  end
endmodule
